// *** dscd_decoder.sv ***
// Command word decoder and power state machine of the drive
`default_nettype none
module dscd_decoder
  import dscd_pkg::*;
(
  input  wire logic        clk_i,              // 100 MHz clock
  input  wire logic        rst_b_i,            // Async reset, active low
  input  wire logic        cmd_wr_i,           // Command word write strobe
  input  wire logic [15:0] cmd_data_i,         // Command word write data
  output logic      [15:0] cmd_word_o,         // Command word read back
  output logic      [15:0] status_o,           // Status word
  output dscd_state_t      state_o,            // Current power state
  input  wire logic        fault_det_i,        // Fault detected, level
  input  wire logic        fault_react_done_i, // Fault action finished
  input  wire logic        fault_react_pwr_i,  // Power motor during reaction
  input  wire logic        fault_react_sup_i,  // Supply needed in reaction
  input  wire logic        stop_done_i,        // Motor came to rest
  input  wire logic        line_supply_i,      // Pin: supply present
  input  wire logic        term_fast_i,        // Pin: fast stop terminal
  input  wire logic        term_free_i,        // Pin: freewheel terminal
  input  wire logic        stop_key_i,         // Pin: stop key
  input  wire logic        disop_opt_i,        // 0 freewheel, 1 ramp
  input  wire logic        fast_halt_mode_i,   // FST2 or FST6
  input  wire logic [1:0]  stop_type_i,        // Stop type for halt
  input  wire logic [1:0]  assign_code_bit11_i, // Function of bit 11
  input  wire logic [1:0]  assign_code_bit12_i, // Function of bit 12
  input  wire logic [1:0]  assign_code_bit13_i, // Function of bit 13
  input  wire logic [1:0]  assign_code_bit14_i, // Function of bit 14
  input  wire logic [1:0]  assign_code_bit15_i, // Function of bit 15
  input  wire logic        cfg_req_i,          // Config change request
  output logic             cfg_accept_o,       // Change taken
  output logic             cfg_reject_o,       // Change refused
  output logic             motor_power_o,      // Power stage on
  output logic             supply_req_o,       // Line supply required
  output logic             contactor_o,        // Line contactor closed
  output logic             halt_o,             // Halt in progress
  output logic             stop_req_o,         // Decelerate request
  output logic      [1:0]  stop_kind_o,        // Stop type in use
  output logic             reverse_o           // Reverse direction asked
);

  dscd_state_t       st_q, st_d;
  logic [CW_W-1:0]   cmd_q;
  logic [3:0]        sync1_q, sync2_q;
  logic              fault_ack, shutdown, sw, ev, qsn, enop, halt;
  logic              fast_req, free_req, dir_bit, key, ramp_pend;
  logic              qs_done_q, qs_fault_q;
  logic [1:0]        asg [ASG_N];

  // Effective function of an assignable bit
  function automatic logic [1:0] asg_eff(input logic [1:0] code, input logic first);
    asg_eff = (first && code == ASG_NONE) ? ASG_DIR : code;
  endfunction

  // Status image for a state, before the live bits
  function automatic logic [15:0] stw_of(input dscd_state_t s, input logic qsf);
    case (s)
      ST_SWON_DIS: stw_of = STW_SWDIS;
      ST_READY:    stw_of = STW_READY;
      ST_SWON:     stw_of = STW_SWON;
      ST_OPEN:     stw_of = STW_OPEN;
      ST_QSTOP:    stw_of = STW_QSTOP;
      ST_FREACT:   stw_of = STW_FREACT;
      ST_FAULT:    stw_of = qsf ? STW_FAULTQS : STW_FAULT;
      default:     stw_of = STW_NRDY;
    endcase
  endfunction

  // Pins pass two flops before anything looks at them
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {stop_key_i, term_free_i, term_fast_i, line_supply_i};
      sync2_q <= sync1_q;
    end
  end

  // Command word; reserved bits never stored so they cannot steer anything
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_q <= CW_RST;
    end else if (cmd_wr_i) begin
      cmd_q <= cmd_data_i & ~CW_RSVD_MSK;
    end
  end

  // Bit decode
  assign sw        = cmd_q[B_SWON];
  assign ev        = cmd_q[B_ENV];
  assign qsn       = cmd_q[B_QSN];
  assign enop      = cmd_q[B_ENOP];
  assign halt      = cmd_q[B_HALT];
  assign key       = sync2_q[3];
  assign shutdown  = ev && qsn && !sw;
  // Ack only on a written rising edge of bit 7, rest of word ignored
  assign fault_ack = cmd_wr_i && cmd_data_i[B_FRST] && !cmd_q[B_FRST];

  assign asg[0] = assign_code_bit11_i;
  assign asg[1] = assign_code_bit12_i;
  assign asg[2] = assign_code_bit13_i;
  assign asg[3] = assign_code_bit14_i;
  assign asg[4] = assign_code_bit15_i;

  // Assignable bits joined with the terminal requests
  always_comb begin
    fast_req = sync2_q[1];
    free_req = sync2_q[2];
    dir_bit  = 1'b0;
    for (int i = 0; i < ASG_N; i++) begin
      case (asg_eff(asg[i], i == 0))
        ASG_DIR:  dir_bit  = dir_bit | cmd_q[B_ASG+i];
        ASG_FAST: fast_req = fast_req | cmd_q[B_ASG+i];
        ASG_FREE: free_req = free_req | cmd_q[B_ASG+i];
        default:  ;
      endcase
    end
  end

  // Disable operation with ramp option holds run until rest
  assign ramp_pend = (st_q == ST_OPEN) && ev && qsn && sw && !enop && disop_opt_i;

  // Config changes only in the unpowered states
  always_comb begin
    cfg_accept_o = 1'b0;
    cfg_reject_o = 1'b0;
    if (cfg_req_i) begin
      if (st_q == ST_OPEN || st_q == ST_QSTOP || st_q == ST_FREACT)
        cfg_reject_o = 1'b1;
      else
        cfg_accept_o = 1'b1;
    end
  end

  // Next state; faults and voltage loss take priority over run commands
  always_comb begin
    st_d = st_q;
    if (st_q == ST_NOT_READY) begin
      st_d = ST_SWON_DIS;
    end else if (fault_det_i && st_q != ST_FREACT && st_q != ST_FAULT) begin
      st_d = ST_FREACT;
    end else begin
      case (st_q)
        ST_FREACT: if (fault_react_done_i) st_d = ST_FAULT;
        ST_FAULT:  if (fault_ack) st_d = ST_SWON_DIS;
        ST_SWON_DIS: if (shutdown && !free_req) st_d = ST_READY;
        ST_READY: begin
          if (free_req || !ev || !qsn) st_d = ST_SWON_DIS;
          else if (sw) st_d = ST_SWON;
        end
        ST_SWON: begin
          if (free_req || !ev || !qsn || cfg_accept_o) begin
            st_d = ST_SWON_DIS;
          end else if (!sw) begin
            st_d = ST_READY;
          end else if (enop && !fast_req) begin // Held fast stop blocks re-enable
            st_d = ST_OPEN;
          end
        end
        ST_OPEN: begin
          if (free_req || !ev) st_d = ST_SWON_DIS;
          else if (!qsn) st_d = ST_QSTOP;
          else if (!sw) st_d = ST_READY;
          else if (fast_req) st_d = ST_SWON;
          else if (!enop && (!disop_opt_i || stop_done_i)) st_d = ST_SWON;
        end
        ST_QSTOP: begin
          if (free_req || !ev || key) st_d = ST_SWON_DIS;
          else if (fast_halt_mode_i == FST2 && stop_done_i) st_d = ST_SWON_DIS;
        end
        default: st_d = ST_NOT_READY;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) st_q <= ST_NOT_READY;
    else          st_q <= st_d;
  end

  // Quick stop bookkeeping: motor at rest, fault seen after quick stop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      qs_done_q  <= 1'b0;
      qs_fault_q <= 1'b0;
    end else begin
      qs_done_q <= (st_d == ST_QSTOP) && (qs_done_q || (st_q == ST_QSTOP && stop_done_i));
      if (st_q == ST_QSTOP && st_d == ST_FREACT) qs_fault_q <= 1'b1;
      else if (st_d != ST_FREACT && st_d != ST_FAULT) qs_fault_q <= 1'b0;
    end
  end

  // Drive outputs, registered so they line up with the state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      motor_power_o <= 1'b0;
      supply_req_o  <= 1'b0;
      contactor_o   <= 1'b0;
      halt_o        <= 1'b0;
      stop_req_o    <= 1'b0;
      stop_kind_o   <= STP_FAST;
      reverse_o     <= 1'b0;
    end else begin
      halt_o    <= (st_d == ST_OPEN) && halt;
      reverse_o <= dir_bit;
      case (st_d)
        ST_OPEN:   motor_power_o <= !halt;
        ST_QSTOP:  motor_power_o <= !qs_done_q;
        ST_FREACT: motor_power_o <= fault_react_pwr_i;
        default:   motor_power_o <= 1'b0;
      endcase
      case (st_d)
        ST_SWON, ST_OPEN, ST_QSTOP: supply_req_o <= 1'b1;
        ST_FREACT:                  supply_req_o <= fault_react_sup_i;
        default:                    supply_req_o <= 1'b0;
      endcase
      contactor_o <= (st_d == ST_SWON) || (st_d == ST_OPEN) || (st_d == ST_QSTOP);
      if (st_d == ST_QSTOP) begin
        stop_req_o  <= 1'b1;
        stop_kind_o <= STP_FAST;
      end else if ((st_d == ST_OPEN) && halt) begin
        stop_req_o  <= 1'b1;
        stop_kind_o <= stop_type_i;
      end else begin
        stop_req_o  <= ramp_pend && (st_d == ST_OPEN);
        stop_kind_o <= STP_RAMP;
      end
    end
  end

  // Status word; voltage bit is live supply, direction echoes request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_o <= STW_NRDY;
    end else begin
      status_o           <= stw_of(st_d, qs_fault_q || (st_q == ST_QSTOP));
      status_o[STW_VOLT] <= sync2_q[0];
      status_o[STW_DIR]  <= dir_bit;
    end
  end

  assign cmd_word_o = cmd_q;
  assign state_o    = st_q;

  // Checks
  fault_react_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_FREACT && fault_react_done_i |=> st_q == ST_FAULT)
    else $error("fault reaction did not end in fault");
  fault_lock_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_FAULT && !fault_ack |=> st_q == ST_FAULT && !motor_power_o)
    else $error("fault state left or powered");
  power_state_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    motor_power_o |-> st_q inside {ST_OPEN, ST_QSTOP, ST_FREACT})
    else $error("motor powered in wrong state");
  supply_need_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q inside {ST_SWON, ST_OPEN, ST_QSTOP} |-> supply_req_o)
    else $error("line supply not required");
  cfg_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg_req_i && st_q inside {ST_OPEN, ST_QSTOP} |-> cfg_reject_o && !cfg_accept_o)
    else $error("config change not refused");
  cfg_swon_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_SWON && cfg_req_i && !fault_det_i |=> st_q == ST_SWON_DIS)
    else $error("config change did not disable");
  fault_ack_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_FAULT && cmd_wr_i && cmd_data_i[B_FRST] && !cmd_q[B_FRST]
    |=> st_q == ST_SWON_DIS && (status_o & STW_MASK) == STW_SWDIS)
    else $error("fault acknowledge failed");
  volt_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q inside {ST_READY, ST_SWON, ST_OPEN, ST_QSTOP} && !ev && !fault_det_i
    |=> st_q == ST_SWON_DIS)
    else $error("voltage disable ignored");
  quick_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_OPEN && ev && !qsn && !free_req && !fault_det_i |=> st_q == ST_QSTOP)
    else $error("quick stop not entered");
  halt_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_o |-> st_q == ST_OPEN && !motor_power_o && stop_req_o)
    else $error("halt left run or powered");
  stw_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_OPEN |-> (status_o & STW_MASK) == STW_OPEN)
    else $error("status mask wrong in run");

  run_c:   cover property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_SWON ##1 st_q == ST_OPEN);
  qstop_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_QSTOP ##1 st_q == ST_SWON_DIS);
  fault_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    st_q == ST_FAULT ##1 st_q == ST_SWON_DIS);
  halt_c:  cover property (@(posedge clk_i) disable iff (!rst_b_i) halt_o);

endmodule : dscd_decoder
`default_nettype wire

// *** dscd_master_model.sv ***
// Network master model that writes the drive command word
`default_nettype none
module dscd_master_model
  import dscd_pkg::*;
(
  input  wire logic        clk_i,      // Decoder clock
  output logic             cmd_wr_o,   // Write strobe, one cycle
  output logic      [15:0] cmd_data_o  // Command word data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    cmd_wr_o   = 1'b0;
    cmd_data_o = 16'h0000;
  end

  // One write: set after a falling edge, held over the taking edge
  task automatic wr(input logic [15:0] d, input logic keep_rsv);
    @(negedge clk_i);
    cmd_wr_o   = 1'b1;
    cmd_data_o = keep_rsv ? d : (d & ~CW_RSVD_MSK);
    @(negedge clk_i);
    cmd_wr_o   = 1'b0;
    // Stale data is inverted so nothing relies on a held value
    cmd_data_o = ~cmd_data_o;
  endtask
endmodule // dscd_master_model
`default_nettype wire

// *** dscd_pkg.sv ***
// Constants and types for the drive state command decoder
`default_nettype none
package dscd_pkg;
  // Drive power states, in the order of the state chart
  typedef enum logic [2:0] {
    ST_NOT_READY, ST_SWON_DIS, ST_READY, ST_SWON,
    ST_OPEN, ST_QSTOP, ST_FREACT, ST_FAULT
  } dscd_state_t;

  localparam int          CW_W        = 16;
  localparam logic [15:0] CW_RST      = 16'h0000;
  localparam logic [15:0] CW_RSVD_MSK = 16'h0670; // Bits 4,5,6,9,10
  // Command word bit positions
  localparam int B_SWON = 0;   // Contactor control / switch on
  localparam int B_ENV  = 1;   // Enable voltage
  localparam int B_QSN  = 2;   // Quick stop, active low
  localparam int B_ENOP = 3;   // Run command
  localparam int B_FRST = 7;   // Fault reset, rising edge
  localparam int B_HALT = 8;
  localparam int B_ASG  = 11;  // First assignable bit
  localparam int ASG_N  = 5;   // Bits 11..15

  // Function selected by an assignment code
  localparam logic [1:0] ASG_NONE = 2'h0; // Bit 11 falls back to direction
  localparam logic [1:0] ASG_DIR  = 2'h1;
  localparam logic [1:0] ASG_FAST = 2'h2;
  localparam logic [1:0] ASG_FREE = 2'h3;

  // Configured stop types
  localparam logic [1:0] STP_FAST = 2'h0;
  localparam logic [1:0] STP_RAMP = 2'h1;
  localparam logic [1:0] STP_FREE = 2'h2;
  localparam logic [1:0] STP_DCI  = 2'h3;

  localparam logic FST2 = 1'b0;
  localparam logic FST6 = 1'b1;

  // Status word images, masked part
  localparam logic [15:0] STW_MASK    = 16'h006f;
  localparam logic [15:0] STW_NRDY    = 16'h0000;
  localparam logic [15:0] STW_SWDIS   = 16'h0040;
  localparam logic [15:0] STW_READY   = 16'h0021;
  localparam logic [15:0] STW_SWON    = 16'h0023;
  localparam logic [15:0] STW_OPEN    = 16'h0027;
  localparam logic [15:0] STW_QSTOP   = 16'h0007;
  localparam logic [15:0] STW_FREACT  = 16'h000f;
  localparam logic [15:0] STW_FAULT   = 16'h0008;
  localparam logic [15:0] STW_FAULTQS = 16'h0028;
  localparam int          STW_VOLT    = 4;
  localparam int          STW_DIR     = 15;
endpackage : dscd_pkg
`default_nettype wire

// *** test_dscd_decoder.sv ***
// Self-checking bench for the drive state command decoder
`default_nettype none
module test_dscd_decoder
  import dscd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cmd_wr_i;
  logic [15:0] cmd_data_i, cmd_word_o, status_o;
  dscd_state_t state_o;
  logic        fault_det_i, fault_react_done_i, fault_react_pwr_i, fault_react_sup_i;
  logic        stop_done_i, line_supply_i, term_fast_i, term_free_i, stop_key_i;
  logic        disop_opt_i, fast_halt_mode_i, cfg_req_i, cfg_accept_o, cfg_reject_o;
  logic        motor_power_o, supply_req_o, contactor_o, halt_o, stop_req_o, reverse_o;
  logic [1:0]  stop_type_i, stop_kind_o, assign_code_bit11_i, assign_code_bit12_i;
  logic [1:0]  assign_code_bit13_i, assign_code_bit14_i, assign_code_bit15_i;
  int          fails = 0;
  int          checks = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  dscd_master_model u_dscd_master_model (
    .clk_i, .cmd_wr_o(cmd_wr_i), .cmd_data_o(cmd_data_i));

  dscd_decoder u_dscd_decoder (
    .clk_i, .rst_b_i, .cmd_wr_i, .cmd_data_i, .cmd_word_o, .status_o, .state_o,
    .fault_det_i, .fault_react_done_i, .fault_react_pwr_i, .fault_react_sup_i,
    .stop_done_i, .line_supply_i, .term_fast_i, .term_free_i, .stop_key_i,
    .disop_opt_i, .fast_halt_mode_i, .stop_type_i, .assign_code_bit11_i,
    .assign_code_bit12_i, .assign_code_bit13_i, .assign_code_bit14_i,
    .assign_code_bit15_i, .cfg_req_i, .cfg_accept_o, .cfg_reject_o, .motor_power_o,
    .supply_req_o, .contactor_o, .halt_o, .stop_req_o, .stop_kind_o, .reverse_o);

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Word compare, case equality so an unknown never matches
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Single flag compare
  task automatic chk1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask

  // State compare; bounded wait, a miss ends the run
  task automatic wait_st(input dscd_state_t e);
    for (int i = 0; i < 12 && state_o !== e; i++) @(negedge clk_i);
    checks++;
    if (state_o !== e) begin
      fails++;
      $display("CHECK FAILED state expected %s seen %s", e.name(), state_o.name());
      print_verdict();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic [15:0] d);
    u_dscd_master_model.wr(d, 1'b0);
  endtask

  // From switch on disabled up to operation enabled
  task automatic go_open();
    wr(16'h0006);
    wait_st(ST_READY);
    wr(16'h0007);
    wait_st(ST_SWON);
    wr(16'h000f);
    wait_st(ST_OPEN);
    cyc(2);
  endtask

  task automatic t_reset();
    wait_st(ST_SWON_DIS);
    cyc(2);
    chk("status", STW_SWDIS, status_o & STW_MASK);
    chk("cmd_word", CW_RST, cmd_word_o);
  endtask

  task automatic t_seq();
    line_supply_i = 1'b1;
    wr(16'h0006);
    wait_st(ST_READY);
    cyc(2);
    chk("status", STW_READY, status_o & STW_MASK);
    chk1("supply_req", 1'b0, supply_req_o);
    chk1("volt_bit", 1'b1, status_o[STW_VOLT]);
    chk1("contactor", 1'b0, contactor_o);
    wr(16'h0007);
    wait_st(ST_SWON);
    cyc(2);
    chk("status", STW_SWON, status_o & STW_MASK);
    chk1("contactor", 1'b1, contactor_o);
    chk1("supply_req", 1'b1, supply_req_o);
    chk1("motor", 1'b0, motor_power_o);
    wr(16'h000f);
    wait_st(ST_OPEN);
    cyc(2);
    chk("status", STW_OPEN, status_o & STW_MASK);
    chk1("motor", 1'b1, motor_power_o);
    disop_opt_i = 1'b0;
    wr(16'h0007);
    wait_st(ST_SWON);
    cyc(2);
    chk1("motor", 1'b0, motor_power_o);
  endtask

  // Config change taken in switched on, refused while running
  task automatic t_cfg();
    cfg_req_i = 1'b1;
    #1 chk1("cfg_accept", 1'b1, cfg_accept_o);
    @(negedge clk_i);
    cfg_req_i = 1'b0;
    wait_st(ST_SWON_DIS);
    go_open();
    cfg_req_i = 1'b1;
    #1 chk1("cfg_reject", 1'b1, cfg_reject_o);
    chk1("cfg_accept", 1'b0, cfg_accept_o);
    @(negedge clk_i);
    cfg_req_i = 1'b0;
    cyc(3);
    wait_st(ST_OPEN);
  endtask

  // Halt under every stop type keeps the run state
  task automatic t_halt();
    for (int k = 0; k < 4; k++) begin
      stop_type_i = 2'(k);
      wr(16'h010f);
      cyc(3);
      wait_st(ST_OPEN);
      chk1("halt", 1'b1, halt_o);
      chk1("stop_req", 1'b1, stop_req_o);
      chk1("motor", 1'b0, motor_power_o);
      chk("stop_kind", 16'(k), {14'h0000, stop_kind_o});
      wr(16'h000f);
      cyc(3);
    end
  endtask

  task automatic t_qstop();
    fast_halt_mode_i = FST2;
    wr(16'h0002);
    wait_st(ST_QSTOP);
    cyc(2);
    chk("status", STW_QSTOP, status_o & STW_MASK);
    chk1("motor", 1'b1, motor_power_o);
    stop_done_i = 1'b1;
    wait_st(ST_SWON_DIS);
    stop_done_i = 1'b0;
    go_open();
    wr(16'h000d);
    wait_st(ST_SWON_DIS);
  endtask

  task automatic t_fault();
    go_open();
    fault_react_pwr_i = 1'b0;
    fault_react_sup_i = 1'b1;
    fault_det_i = 1'b1;
    wait_st(ST_FREACT);
    cyc(2);
    chk1("motor", 1'b0, motor_power_o);
    chk1("supply_req", 1'b1, supply_req_o);
    fault_react_done_i = 1'b1;
    wait_st(ST_FAULT);
    fault_det_i = 1'b0;
    fault_react_done_i = 1'b0;
    cyc(2);
    chk1("motor", 1'b0, motor_power_o);
    chk("status", STW_FAULT, status_o & STW_MASK);
    wr(16'h0006);
    cyc(4);
    wait_st(ST_FAULT);
    wr(16'h0080);
    wait_st(ST_SWON_DIS);
  endtask

  // Ramp disable option, held terminal fast stop, FST6 ended by the stop key
  task automatic t_modes();
    go_open();
    disop_opt_i = 1'b1;
    wr(16'h0007);
    cyc(3);
    wait_st(ST_OPEN);
    chk1("stop_req", 1'b1, stop_req_o);
    chk("stop_kind", 16'(STP_RAMP), {14'h0000, stop_kind_o});
    stop_done_i = 1'b1;
    wait_st(ST_SWON);
    stop_done_i = 1'b0;
    disop_opt_i = 1'b0;
    wr(16'h000f);
    wait_st(ST_OPEN);
    term_fast_i = 1'b1;
    wait_st(ST_SWON);
    cyc(3);
    chk("state", 16'(ST_SWON), 16'(state_o));
    term_fast_i = 1'b0;
    wait_st(ST_OPEN);
    fast_halt_mode_i = FST6;
    wr(16'h0002);
    wait_st(ST_QSTOP);
    stop_done_i = 1'b1;
    cyc(4);
    chk("state", 16'(ST_QSTOP), 16'(state_o));
    chk1("motor", 1'b0, motor_power_o);
    stop_key_i = 1'b1;
    wait_st(ST_SWON_DIS);
    {stop_key_i, stop_done_i, fast_halt_mode_i} = 3'h0;
  endtask

  // Reserved bits, direction bit and assigned stop bits
  task automatic t_assign();
    assign_code_bit11_i = ASG_NONE;
    assign_code_bit12_i = ASG_FAST;
    assign_code_bit13_i = ASG_FREE;
    u_dscd_master_model.wr(16'h0e76, 1'b1);
    chk("cmd_word", 16'h0806, cmd_word_o);
    wait_st(ST_READY);
    cyc(2);
    chk1("reverse", 1'b1, reverse_o);
    wr(16'h0007);
    wait_st(ST_SWON);
    wr(16'h000f);
    wait_st(ST_OPEN);
    wr(16'h100f);
    wait_st(ST_SWON);
    wr(16'h000f);
    wait_st(ST_OPEN);
    wr(16'h200f);
    wait_st(ST_SWON_DIS);
  endtask

  // Main sequence: every input set at time zero, reset for 10 cycles
  initial begin
    {fault_det_i, fault_react_done_i, fault_react_pwr_i, fault_react_sup_i} = 4'h0;
    {stop_done_i, line_supply_i, term_fast_i, term_free_i, stop_key_i} = 5'h00;
    {disop_opt_i, fast_halt_mode_i, cfg_req_i} = 3'h0;
    stop_type_i = STP_FAST;
    {assign_code_bit11_i, assign_code_bit12_i, assign_code_bit13_i} = 6'h00;
    {assign_code_bit14_i, assign_code_bit15_i} = 4'h0;
    cyc(10);
    rst_b_i = 1'b1;
    t_reset();
    t_seq();
    t_cfg();
    t_halt();
    t_qstop();
    t_fault();
    t_modes();
    t_assign();
    print_verdict();
  end
endmodule // test_dscd_decoder
`default_nettype wire
